//--- core/ccic_consts.svh
// Offsets, field positions and reset values of the chop and channel config block
`ifndef CCIC_CONSTS_SVH
`define CCIC_CONSTS_SVH

// Register indices as printed; byte address is four times the index
`define CCIC_IDX_CHOP 8'h06
`define CCIC_IDX_CH0 8'h09
`define CCIC_IDX_CH1 8'h0e
`define CCIC_IDX_STAT 8'h20
`define CCIC_IDX_CTRL 8'h21

// Chop configuration fields
`define CCIC_DLY_MSB 12
`define CCIC_DLY_LSB 9
`define CCIC_EN_BIT 8
`define CCIC_CHOP_RST 16'h0600

// Channel configuration fields
`define CCIC_SEL_MSB 1
`define CCIC_SEL_LSB 0
`define CCIC_CH_RST 16'h0000
`define CCIC_CH_RO_MASK 16'hffc7

// Control register bit that requests a measurement start
`define CCIC_CTRL_START_BIT 0

`endif

//--- core/ccic_pkg.sv
// Types shared by the chop and channel config block
package ccic_pkg;
  typedef enum logic [1:0] {
    CCIC_SEL_PINS = 2'h0,
    CCIC_SEL_SHORT = 2'h1,
    CCIC_SEL_TEST_POS = 2'h2,
    CCIC_SEL_TEST_NEG = 2'h3
  } ccic_sel_t;

  typedef enum logic [1:0] {
    CCIC_ST_IDLE = 2'b00,
    CCIC_ST_SETTLE = 2'b01,
    CCIC_ST_MEASURE = 2'b11
  } ccic_state_t;
endpackage

//--- core/ccic_chop_if.sv
// Interface between register file and chop settle timer
`timescale 1ns/1ns
interface ccic_chop_if;
  logic enable;
  logic [3:0] delay_code;
  logic start;
  logic settling;
  logic measuring;
  modport regs (output enable, output delay_code, output start, input settling, input measuring);
  modport timer (input enable, input delay_code, input start, output settling, output measuring);
endinterface

//--- core/ccic_settle_timer.sv
// Chop settle timer: counts modulator periods before measurement begins
`timescale 1ns/1ns
`include "ccic_consts.svh"
module ccic_settle_timer
  import ccic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  ccic_chop_if.timer chop
);
  ccic_state_t state;
  ccic_state_t next_state;
  logic [16:0] count;
  logic [16:0] next_count;

  // Period count for a delay code: 2^(n+1)
  function automatic logic [16:0] settle_periods(input logic [3:0] code);
    // Shift 2 by the code so that code 1111b cannot wrap to zero
    settle_periods = 17'h00002 << code;
  endfunction

  // Next state and count
  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      CCIC_ST_IDLE: begin
        if (chop.start && chop.enable) begin
          next_state = CCIC_ST_SETTLE;
          next_count = settle_periods(chop.delay_code) - 17'h00001;
        end else if (chop.start) begin
          next_state = CCIC_ST_MEASURE;
        end
      end
      CCIC_ST_SETTLE: begin
        if (count == 17'h00000) begin
          next_state = CCIC_ST_MEASURE;
        end else begin
          next_count = count - 17'h00001;
        end
      end
      CCIC_ST_MEASURE: begin
        next_state = CCIC_ST_IDLE;
      end
      default: begin
        next_state = CCIC_ST_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= CCIC_ST_IDLE;
      count <= 17'h00000;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign chop.settling = (state == CCIC_ST_SETTLE);
  assign chop.measuring = (state == CCIC_ST_MEASURE);
endmodule

//--- core/ccic_top.sv
// Chop and channel input configuration registers with APB slave
//
// Overview of operation
// - With chop on, wait a settling delay in modulator periods before measuring.
// - Chop enable bit 8 turns global chop on; resets off.
// - Channel select bits 1:0: 00b own pins, 01b inputs shorted; reset 00b.
// - Select 10b routes positive dc test signal, 11b negative.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
`include "ccic_consts.svh"
module ccic_top
  import ccic_pkg::*;
(
  // Clock and reset (CLK is the modulator clock)
  input wire logic CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Configuration outputs
  output logic CHOP_ENABLE,
  output logic [3:0] CHOP_SETTLE_DELAY,
  output logic [1:0] CH0_INPUT_SELECT,
  output logic [1:0] CH1_INPUT_SELECT,
  // Analog routing controls per channel (0 and 1)
  output logic [1:0] CONNECT_PINS,
  output logic [1:0] SHORT_INPUTS,
  output logic [1:0] TEST_POS,
  output logic [1:0] TEST_NEG,
  // Measurement status
  output logic SETTLING,
  output logic MEASURE_START
);
  localparam int NCH = 2;

  ccic_chop_if chop_bus ();

  logic [15:0] chop_cfg;
  logic [15:0] ch_cfg [NCH];
  logic [15:0] next_chop_cfg;
  logic [15:0] next_ch_cfg [NCH];
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic start_req;
  logic next_start_req;
  logic [NCH-1:0] next_pins;
  logic [NCH-1:0] next_short;
  logic [NCH-1:0] next_tpos;
  logic [NCH-1:0] next_tneg;

  // Index decode of a byte address; address bits 1:0 are ignored, so unaligned addresses are not rejected
  function automatic logic [9:0] word_index(input logic [11:0] addr);
    word_index = addr[11:2];
  endfunction

  function automatic logic is_mapped(input logic [11:0] addr);
    logic [9:0] idx;
    idx = word_index(addr);
    is_mapped = (idx == {2'h0, `CCIC_IDX_CHOP}) || (idx == {2'h0, `CCIC_IDX_CH0}) ||
                (idx == {2'h0, `CCIC_IDX_CH1}) || (idx == {2'h0, `CCIC_IDX_STAT}) ||
                (idx == {2'h0, `CCIC_IDX_CTRL});
  endfunction

  wire access = PSEL && PENABLE && !PREADY;
  wire wr = access && PWRITE && is_mapped(PADDR);
  wire [9:0] idx = word_index(PADDR);

  // Register writes and read mux; one wait state per access
  always_comb begin
    next_chop_cfg = chop_cfg;
    for (int i = 0; i < NCH; i++) begin
      next_ch_cfg[i] = ch_cfg[i];
    end
    next_start_req = 1'b0;
    next_prdata = 32'h00000000;
    next_pready = access;
    next_pslverr = access && !is_mapped(PADDR);
    if (wr) begin
      case (idx)
        {2'h0, `CCIC_IDX_CHOP}: next_chop_cfg = PWDATA[15:0];
        {2'h0, `CCIC_IDX_CH0}: next_ch_cfg[0] = PWDATA[15:0] & `CCIC_CH_RO_MASK;
        {2'h0, `CCIC_IDX_CH1}: next_ch_cfg[1] = PWDATA[15:0] & `CCIC_CH_RO_MASK;
        {2'h0, `CCIC_IDX_CTRL}: next_start_req = PWDATA[`CCIC_CTRL_START_BIT];
        default: next_start_req = 1'b0;
      endcase
    end
    if (access && !PWRITE) begin
      case (idx)
        {2'h0, `CCIC_IDX_CHOP}: next_prdata = {16'h0000, chop_cfg};
        {2'h0, `CCIC_IDX_CH0}: next_prdata = {16'h0000, ch_cfg[0]};
        {2'h0, `CCIC_IDX_CH1}: next_prdata = {16'h0000, ch_cfg[1]};
        {2'h0, `CCIC_IDX_STAT}: next_prdata = {30'h0, chop_bus.measuring, chop_bus.settling};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  // Input routing decode per channel
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_route
      wire [1:0] sel = ch_cfg[g][`CCIC_SEL_MSB:`CCIC_SEL_LSB];
      assign next_pins[g] = (sel == CCIC_SEL_PINS);
      assign next_short[g] = (sel == CCIC_SEL_SHORT);
      assign next_tpos[g] = (sel == CCIC_SEL_TEST_POS);
      assign next_tneg[g] = (sel == CCIC_SEL_TEST_NEG);
    end
  endgenerate

  // Registers and outputs
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      chop_cfg <= `CCIC_CHOP_RST;
      for (int i = 0; i < NCH; i++) begin
        ch_cfg[i] <= `CCIC_CH_RST;
      end
      start_req <= 1'b0;
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      CHOP_ENABLE <= 1'b0;
      CHOP_SETTLE_DELAY <= 4'h3;
      CH0_INPUT_SELECT <= 2'h0;
      CH1_INPUT_SELECT <= 2'h0;
      CONNECT_PINS <= 2'h3;
      SHORT_INPUTS <= 2'h0;
      TEST_POS <= 2'h0;
      TEST_NEG <= 2'h0;
      SETTLING <= 1'b0;
      MEASURE_START <= 1'b0;
    end else begin
      chop_cfg <= next_chop_cfg;
      for (int i = 0; i < NCH; i++) begin
        ch_cfg[i] <= next_ch_cfg[i];
      end
      start_req <= next_start_req;
      PRDATA <= next_prdata;
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
      CHOP_ENABLE <= chop_cfg[`CCIC_EN_BIT];
      CHOP_SETTLE_DELAY <= chop_cfg[`CCIC_DLY_MSB:`CCIC_DLY_LSB];
      CH0_INPUT_SELECT <= ch_cfg[0][`CCIC_SEL_MSB:`CCIC_SEL_LSB];
      CH1_INPUT_SELECT <= ch_cfg[1][`CCIC_SEL_MSB:`CCIC_SEL_LSB];
      CONNECT_PINS <= next_pins;
      SHORT_INPUTS <= next_short;
      TEST_POS <= next_tpos;
      TEST_NEG <= next_tneg;
      SETTLING <= chop_bus.settling;
      MEASURE_START <= chop_bus.measuring;
    end
  end

  // Timer control
  assign chop_bus.enable = chop_cfg[`CCIC_EN_BIT];
  assign chop_bus.delay_code = chop_cfg[`CCIC_DLY_MSB:`CCIC_DLY_LSB];
  assign chop_bus.start = start_req;

  ccic_settle_timer u_timer (
    .clk(CLK),
    .rst_n(RST_N),
    .chop(chop_bus)
  );
endmodule

//--- sim/ccic_monitor.sv
// Assertion checker for the chop and channel config block
`timescale 1ns/1ns
module ccic_monitor (
  // Clock, reset, APB
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Config and status
  input wire logic CHOP_ENABLE,
  input wire logic [3:0] CHOP_SETTLE_DELAY,
  input wire logic [1:0] CH0_INPUT_SELECT,
  input wire logic [1:0] CH1_INPUT_SELECT,
  input wire logic [1:0] CONNECT_PINS,
  input wire logic [1:0] SHORT_INPUTS,
  input wire logic [1:0] TEST_POS,
  input wire logic [1:0] TEST_NEG,
  input wire logic SETTLING,
  input wire logic MEASURE_START
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [16:0] run;
  // Length of the current settling run
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      run <= 17'h0;
    else
      run <= SETTLING ? run + 17'h1 : 17'h0;
  end
  a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready late");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready too long");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_ch0_route: assert property ({TEST_NEG[0], TEST_POS[0], SHORT_INPUTS[0],
    CONNECT_PINS[0]} == 4'h1 << CH0_INPUT_SELECT) else $error("ch0 routing");
  a_ch1_route: assert property ({TEST_NEG[1], TEST_POS[1], SHORT_INPUTS[1],
    CONNECT_PINS[1]} == 4'h1 << CH1_INPUT_SELECT) else $error("ch1 routing");
  a_settle_len: assert property ($fell(SETTLING) |-> run == 17'h2 << CHOP_SETTLE_DELAY)
    else $error("settle length");
  a_start_after: assert property ($fell(SETTLING) |-> ##[0:1] MEASURE_START)
    else $error("no start after settle");
  a_start_pulse: assert property (MEASURE_START |=> !MEASURE_START)
    else $error("start too long");
  a_settle_chop: assert property ($rose(SETTLING) |-> CHOP_ENABLE)
    else $error("settle with chop off");
endmodule
bind ccic_top ccic_monitor i_mon (.*);

//--- sim/tb_top.sv
// Self-checking bench for the chop and channel config block
`timescale 1ns/1ns
`include "ccic_consts.svh"
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, d;
  logic pready, pslverr, chop_en, settling, mstart;
  logic [3:0] dly;
  logic [1:0] sel0, sel1, conn, shrt, tpos, tneg;
  int error_cnt = 0;
  int n_checks = 0;
  int seed = 32'ha7bd0b25;
  int s_cnt, ms_cnt, c;
  int mdl[int];
  ccic_top i_dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CHOP_ENABLE(chop_en),
    .CHOP_SETTLE_DELAY(dly), .CH0_INPUT_SELECT(sel0), .CH1_INPUT_SELECT(sel1),
    .CONNECT_PINS(conn), .SHORT_INPUTS(shrt), .TEST_POS(tpos), .TEST_NEG(tneg),
    .SETTLING(settling), .MEASURE_START(mstart));
  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end
  // Tally settling cycles and start pulses
  always @(negedge clk) begin
    if (settling === 1'b1) s_cnt++;
    if (mstart === 1'b1) ms_cnt++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer, compared with the register model
  task automatic xfer(input bit w, input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] exp;
    int n;
    exp = mdl.exists(idx) ? mdl[idx] : 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      conclude();
    end
    chk(32'(pslverr), 32'(!mdl.exists(idx)));
    if (!w)
      chk(prdata, exp);
    else if (idx == `CCIC_IDX_CHOP)
      mdl[idx] = wd[15:0];
    else if (idx != `CCIC_IDX_CTRL && mdl.exists(idx))
      mdl[idx] = wd[15:0] & `CCIC_CH_RO_MASK;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Start a measurement, count settling cycles up to the start pulse
  task automatic meas(input int exp);
    int n;
    s_cnt = 0;
    ms_cnt = 0;
    xfer(1'b1, `CCIC_IDX_CTRL, 32'h1);
    n = 0;
    while (ms_cnt == 0 && n < 70000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    if (n >= 70000) error_cnt++;
    chk(s_cnt, exp);
    chk(ms_cnt, 1);
    @(posedge clk);
  endtask
  // Main sequence
  initial begin
    mdl[`CCIC_IDX_CHOP] = 32'h0600;
    mdl[`CCIC_IDX_CH0] = 0;
    mdl[`CCIC_IDX_CH1] = 0;
    mdl[`CCIC_IDX_STAT] = 0;
    mdl[`CCIC_IDX_CTRL] = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk({chop_en, dly, conn}, 7'h0f);
    @(posedge clk);
    foreach (mdl[i]) xfer(1'b0, i[7:0], 32'h0);
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      d = $random(seed) & 32'hffff0003;
      d[1:0] = k[1:0];
      c = k / 4;
      xfer(1'b1, c ? `CCIC_IDX_CH1 : `CCIC_IDX_CH0, d);
      xfer(1'b0, c ? `CCIC_IDX_CH1 : `CCIC_IDX_CH0, 32'h0);
      chk({tneg[c], tpos[c], shrt[c], conn[c], c ? sel1 : sel0}, {4'h1 << k[1:0], k[1:0]});
    end
    $display("select test done");
    xfer(1'b1, 8'h07, $random(seed));
    xfer(1'b0, 8'h07, 32'h0);
    $display("unmapped test done");
    for (int j = 0; j < 4; j++) begin
      c = j == 0 ? 0 : (j == 1 ? 3 : (j == 2 ? 13 : 15));
      d = ($random(seed) & 32'hffff0000) | (c << 9) | 32'h100;
      xfer(1'b1, `CCIC_IDX_CHOP, d);
      xfer(1'b0, `CCIC_IDX_CHOP, 32'h0);
      meas(2 << c);
    end
    xfer(1'b1, `CCIC_IDX_CHOP, 32'h0600);
    meas(0);
    $display("chop test done");
    conclude();
  end
endmodule
